// >>> hdl/dma_sizer_pkg.sv
// Constants, carriers and state types for the DMA transfer alignment sizer
package dma_sizer_pkg;

    // ==========================================================
    // Widths
    localparam int ADDR_W = 32;
    localparam int COUNT_W = 24;
    localparam int THR_W = 8;

    // ==========================================================
    // Host transfer size codes as driven on the size lines
    localparam logic [1:0] SIZ_LONG = 2'h0;
    localparam logic [1:0] SIZ_BYTE = 2'h1;
    localparam logic [1:0] SIZ_WORD = 2'h2;
    localparam logic [1:0] SIZ_LINE = 2'h3;

    // ==========================================================
    // Byte counts moved per cycle, and the burst floor
    localparam logic [COUNT_W-1:0] BYTES_BYTE = 24'h000001;
    localparam logic [COUNT_W-1:0] BYTES_WORD = 24'h000002;
    localparam logic [COUNT_W-1:0] BYTES_LONG = 24'h000004;
    localparam logic [COUNT_W-1:0] BYTES_LINE = 24'h000010;
    localparam logic [COUNT_W-1:0] BURST_MIN_COUNT = 24'h000020;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 24'h000000;

    // ==========================================================
    // Address field positions and values
    localparam int ADDR_ODD_BYTE_BIT = 0;
    localparam int ADDR_ODD_WORD_BIT = 1;
    localparam int LINE_OFS_W = 4;
    localparam logic [LINE_OFS_W-1:0] LINE_OFS_ZERO = 4'h0;
    localparam logic [THR_W-1:0] BEATS_ZERO = 8'h00;
    localparam logic [THR_W-1:0] BEAT_ONE = 8'h01;

    // ==========================================================
    // Sequencer states, Gray coded along idle, bus, done
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUS = 2'b01,
        ST_DONE = 2'b11
    } sizer_fsm_t;

    // One host bus cycle as offered to the bus controller
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [1:0] size;
        logic burst_line;
        logic last_own;
    } host_cycle_t;

    // Block transfer request from the engine core
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [COUNT_W-1:0] count;
        logic [THR_W-1:0] threshold;
    } block_job_t;

    // Whole state of the sizer
    typedef struct packed {
        sizer_fsm_t fsm;
        logic [ADDR_W-1:0] addr;
        logic [COUNT_W-1:0] count;
        logic burst_ok;
        logic head;
        logic [THR_W-1:0] beats;
        logic [THR_W-1:0] threshold;
        host_cycle_t cyc;
        logic done;
    } sizer_state_t;

    // Bytes moved by a cycle of the given size code
    function automatic logic [COUNT_W-1:0] bytes_of(input logic [1:0] size);
        case (size)
            SIZ_BYTE: bytes_of = BYTES_BYTE;
            SIZ_WORD: bytes_of = BYTES_WORD;
            SIZ_LINE: bytes_of = BYTES_LINE;
            default: bytes_of = BYTES_LONG;
        endcase
    endfunction

endpackage

// >>> hdl/dma_transfer_alignment_sizer.sv
// Host bus cycle sizing for misaligned DMA block transfers
`timescale 1ns/10ps
`default_nettype none

module dma_transfer_alignment_sizer (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic start,
    input wire dma_sizer_pkg::block_job_t job,
    input wire logic bus_async,
    output logic cyc_valid,
    output dma_sizer_pkg::host_cycle_t cyc,
    input wire logic cyc_ack,
    input wire logic burst_ack_n,
    input wire logic burst_inhibit_n,
    output logic busy,
    output logic done,
    output logic [dma_sizer_pkg::COUNT_W-1:0] remaining
);
    import dma_sizer_pkg::*;

    sizer_state_t st_reg;
    sizer_state_t st_next;
    logic ack_burst_ok;
    logic [COUNT_W-1:0] cyc_bytes;
    logic [ADDR_W-1:0] addr_adv;
    logic [COUNT_W-1:0] count_adv;
    logic [THR_W-1:0] beats_adv;
    logic head_adv;

    // ==========================================================
    // Cycle planner
    // Picks the widest cycle the address alignment, count and burst permission allow.
    // Comparisons on the count keep the tail from overrunning the block.
    function automatic host_cycle_t plan(
        input logic [ADDR_W-1:0] addr,
        input logic [COUNT_W-1:0] count,
        input logic ok,
        input logic head,
        input logic [THR_W-1:0] beats,
        input logic [THR_W-1:0] thr
    );
        host_cycle_t c;
        logic head_now;
        logic group_end;
        c = '0;
        head_now = head && (addr[LINE_OFS_W-1:0] != LINE_OFS_ZERO);
        group_end = ((beats + BEAT_ONE) >= thr);
        c.addr = addr;
        if (addr[ADDR_ODD_BYTE_BIT] || (count < BYTES_WORD)) begin
            c.size = SIZ_BYTE;
        end else if (addr[ADDR_ODD_WORD_BIT] || (count < BYTES_LONG)) begin
            c.size = SIZ_WORD;
        end else if ((addr[LINE_OFS_W-1:0] != LINE_OFS_ZERO)
                     || (count <= BURST_MIN_COUNT) || !ok) begin
            c.size = SIZ_LONG;
        end else begin
            c.size = SIZ_LINE;
            c.burst_line = 1'b1;
        end
        // No size code covers three bytes, so none can be planned
        if (c.burst_line) begin
            c.last_own = 1'b1;
        end else if (head_now) begin
            c.last_own = 1'b1;
        end else if (count == bytes_of(c.size)) begin
            c.last_own = 1'b1;
        end else if (!ok && (c.size == SIZ_LONG)) begin
            c.last_own = group_end;
        end else begin
            c.last_own = 1'b0;
        end
        return c;
    endfunction

    // ==========================================================
    // Burst permission from the answer of the cycle being acknowledged
    always_comb begin
        if (bus_async) begin
            ack_burst_ok = !burst_ack_n;
        end else begin
            ack_burst_ok = burst_inhibit_n;
        end
    end

    // Advance of address and count by the bytes of the current cycle
    always_comb begin
        cyc_bytes = bytes_of(st_reg.cyc.size);
        addr_adv = st_reg.addr + {{(ADDR_W-COUNT_W){1'b0}}, cyc_bytes};
        count_adv = st_reg.count - cyc_bytes;
        head_adv = st_reg.head && (st_reg.addr[LINE_OFS_W-1:0] != LINE_OFS_ZERO);
        if (st_reg.cyc.last_own) begin
            beats_adv = BEATS_ZERO;
        end else begin
            beats_adv = st_reg.beats + BEAT_ONE;
        end
    end

    // ==========================================================
    // Sequencer next state
    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        case (st_reg.fsm)
            ST_IDLE: begin
                if (start && (job.count != COUNT_ZERO)) begin
                    st_next.fsm = ST_BUS;
                    st_next.addr = job.addr;
                    st_next.count = job.count;
                    st_next.threshold = job.threshold;
                    st_next.burst_ok = 1'b1;
                    st_next.head = 1'b1;
                    st_next.beats = BEATS_ZERO;
                    st_next.cyc = plan(job.addr, job.count, 1'b1, 1'b1,
                                       BEATS_ZERO, job.threshold);
                end else if (start) begin
                    st_next.fsm = ST_DONE;
                end
            end
            ST_BUS: begin
                if (cyc_ack) begin
                    st_next.addr = addr_adv;
                    st_next.count = count_adv;
                    st_next.burst_ok = ack_burst_ok;
                    st_next.head = head_adv;
                    st_next.beats = beats_adv;
                    if (count_adv == COUNT_ZERO) begin
                        st_next.fsm = ST_DONE;
                    end else begin
                        st_next.cyc = plan(addr_adv, count_adv, ack_burst_ok,
                                           head_adv, beats_adv, st_reg.threshold);
                    end
                end
            end
            ST_DONE: begin
                st_next.fsm = ST_IDLE;
                st_next.done = 1'b1;
            end
            default: begin
                st_next.fsm = ST_IDLE;
            end
        endcase
    end

    // State register, synchronous reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs; request is combinational, data from the state register
    assign cyc_valid = (st_reg.fsm == ST_BUS);
    assign cyc = st_reg.cyc;
    assign busy = (st_reg.fsm != ST_IDLE);
    assign done = st_reg.done;
    assign remaining = st_reg.count;

    // ==========================================================
    // Checks
    chk_odd_byte: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && cyc.addr[ADDR_ODD_BYTE_BIT] |-> cyc.size == SIZ_BYTE)
        else $error("odd byte address not served by a byte cycle");

    chk_word_align: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && !cyc.addr[ADDR_ODD_BYTE_BIT] && cyc.addr[ADDR_ODD_WORD_BIT]
        && (remaining >= BYTES_WORD) |-> cyc.size == SIZ_WORD)
        else $error("odd word address not served by a word cycle");

    chk_long_align: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && !cyc.addr[ADDR_ODD_BYTE_BIT] && !cyc.addr[ADDR_ODD_WORD_BIT]
        && (cyc.addr[LINE_OFS_W-1:0] != LINE_OFS_ZERO)
        && (remaining >= BYTES_LONG) |-> cyc.size == SIZ_LONG)
        else $error("long word alignment phase used wrong width");

    chk_line_burst: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && (cyc.addr[LINE_OFS_W-1:0] == LINE_OFS_ZERO)
        && (remaining > BURST_MIN_COUNT) && st_reg.burst_ok
        |-> cyc.size == SIZ_LINE && cyc.burst_line)
        else $error("line burst not used at line boundary");

    chk_line_owner: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && cyc.burst_line && cyc_ack
        |=> cyc.addr == $past(cyc.addr) + {{(ADDR_W-COUNT_W){1'b0}}, BYTES_LINE} || !cyc_valid)
        else $error("line burst did not move sixteen bytes");

    chk_async_off: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && cyc_ack && bus_async && burst_ack_n |=> !cyc.burst_line)
        else $error("burst attempted without acknowledge");

    chk_sync_off: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && cyc_ack && !bus_async && !burst_inhibit_n |=> !cyc.burst_line)
        else $error("burst attempted while inhibited");

    chk_cycle_fits: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid |-> bytes_of(cyc.size) <= remaining)
        else $error("cycle wider than remaining bytes");

    chk_count_step: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && cyc_ack
        |=> remaining == $past(remaining) - bytes_of($past(cyc.size)))
        else $error("count not reduced by bytes moved");

    chk_head_single: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && st_reg.head && (cyc.addr[LINE_OFS_W-1:0] != LINE_OFS_ZERO)
        |-> cyc.last_own)
        else $error("alignment cycle shared an ownership");

    // ==========================================================
    // Size codes, burst permission and ownership ends
    chk_burst_code: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid |-> (cyc.size == SIZ_LINE) == cyc.burst_line)
        else $error("burst marker and size code disagree");

    chk_line_span: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && cyc.burst_line
        |-> (remaining > BURST_MIN_COUNT) && (cyc.addr[LINE_OFS_W-1:0] == LINE_OFS_ZERO))
        else $error("line burst off a boundary or too near the end");

    chk_line_single: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && cyc.burst_line |-> cyc.last_own)
        else $error("line burst did not end its ownership");

    chk_burst_refused: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && !st_reg.burst_ok |-> !cyc.burst_line)
        else $error("line burst planned after refusal");

    // Threshold zero behaves as one, so each long ends its ownership
    chk_group_end: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && !st_reg.burst_ok && (cyc.size == SIZ_LONG)
        && (st_reg.threshold <= BEAT_ONE) |-> cyc.last_own)
        else $error("single beat group kept the ownership");

    // ==========================================================
    // Block tail and block end
    // Once the count is down to the burst floor, bursting never resumes
    chk_tail_nolines: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && cyc_ack && (remaining <= BURST_MIN_COUNT) |=> !cyc.burst_line)
        else $error("line burst after the tail began");

    chk_word_tail: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && cyc_ack && (cyc.size == SIZ_WORD) && (remaining < BYTES_LONG)
        |=> !cyc_valid || (cyc.size == SIZ_BYTE))
        else $error("tail word not followed by a byte or the end");

    // The byte count must land exactly on zero
    chk_done_end: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && cyc_ack && (remaining == bytes_of(cyc.size)) |=> !cyc_valid ##1 done)
        else $error("final cycle not followed by the done pulse");

    chk_done_pulse: assert property (@(posedge clk_sys) disable iff (reset)
        done |=> !done)
        else $error("done held longer than one cycle");

    // ==========================================================
    // Job intake, request hold and reset
    chk_job_load: assert property (@(posedge clk_sys) disable iff (reset)
        start && !busy && (job.count != COUNT_ZERO)
        |=> cyc_valid && (remaining == $past(job.count)) && (cyc.addr == $past(job.addr)))
        else $error("job not loaded into the first cycle");

    // Also shows that a start while busy leaves the pending cycle alone
    chk_cycle_hold: assert property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && !cyc_ack |=> cyc_valid && $stable(cyc) && $stable(remaining))
        else $error("pending cycle changed before its acknowledge");

    // No disable here: this one looks at the reset itself
    chk_reset_idle: assert property (@(posedge clk_sys)
        reset |=> !busy && !cyc_valid && !done && (remaining == COUNT_ZERO))
        else $error("outputs not idle after reset");

    cov_line_burst: cover property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && cyc.burst_line && cyc_ack);
    cov_noncache: cover property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && !st_reg.burst_ok && cyc.size == SIZ_LONG && !cyc.last_own && cyc_ack);
    cov_odd_done: cover property (@(posedge clk_sys) disable iff (reset)
        start && job.addr[ADDR_ODD_BYTE_BIT] ##[1:300] done);

    // Width change inside one ownership, and a start that arrives while busy
    cov_tail_change: cover property (@(posedge clk_sys) disable iff (reset)
        cyc_valid && cyc_ack && !cyc.last_own ##1 cyc_valid && (cyc.size != $past(cyc.size)));
    cov_busy_start: cover property (@(posedge clk_sys) disable iff (reset)
        start && cyc_valid);

endmodule // dma_transfer_alignment_sizer

`default_nettype wire

// >>> dv/host_bus_model.sv
// Host memory bus model that answers the sizer's cycle requests
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Host side of the cycle handshake, prompt or slow
module host_bus_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cyc_valid,
    input wire logic slow,
    input wire logic permit,
    input wire logic bus_async,
    output logic cyc_ack,
    output logic burst_ack_n,
    output logic burst_inhibit_n
);
    logic [1:0] wait_cnt;
    logic flip;

    // Known levels before the first edge
    initial begin
        cyc_ack = 1'b0;
        burst_ack_n = 1'b1;
        burst_inhibit_n = 1'b1;
        wait_cnt = 2'h0;
        flip = 1'b0;
    end

    // Ack pulse per offered cycle; a slow host waits two extra cycles
    always @(posedge clk_sys) begin
        #1;
        flip = ~flip;
        cyc_ack = 1'b0;
        if (reset || !cyc_valid) begin
            wait_cnt = slow ? 2'h2 : 2'h0;
        end else if (wait_cnt != 2'h0) begin
            wait_cnt = wait_cnt - 2'h1;
        end else begin
            cyc_ack = 1'b1;
            wait_cnt = slow ? 2'h2 : 2'h0;
        end
        // Burst answer only valid with the ack; otherwise a moving pattern
        burst_ack_n = (cyc_ack && bus_async) ? ~permit : flip;
        burst_inhibit_n = (cyc_ack && !bus_async) ? permit : ~flip;
    end
endmodule // host_bus_model

`default_nettype wire

// >>> dv/dma_transfer_alignment_sizer_tb_top.sv
// Self-checking testbench for the DMA transfer alignment sizer
`timescale 1ns/10ps
`default_nettype none

module dma_transfer_alignment_sizer_tb_top;
    import dma_sizer_pkg::*;

    logic clk_sys, reset, start, bus_async, slow, permit;
    logic cyc_valid, cyc_ack, burst_ack_n, burst_inhibit_n, busy, done;
    block_job_t job;
    host_cycle_t cyc;
    logic [COUNT_W-1:0] remaining;
    int failures, compares;

    dma_transfer_alignment_sizer u_dma_transfer_alignment_sizer (
        .clk_sys(clk_sys), .reset(reset), .start(start), .job(job), .bus_async(bus_async),
        .cyc_valid(cyc_valid), .cyc(cyc), .cyc_ack(cyc_ack), .burst_ack_n(burst_ack_n),
        .burst_inhibit_n(burst_inhibit_n), .busy(busy), .done(done), .remaining(remaining));

    host_bus_model u_host_bus_model (
        .clk_sys(clk_sys), .reset(reset), .cyc_valid(cyc_valid), .slow(slow),
        .permit(permit), .bus_async(bus_async), .cyc_ack(cyc_ack),
        .burst_ack_n(burst_ack_n), .burst_inhibit_n(burst_inhibit_n));

    // ==========================================================
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            failures++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    task automatic close_out;
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================================
    // One block: reference planner tracks address, count and permission
    task automatic run_block(input logic [31:0] ad, input logic [23:0] ct,
            input logic [7:0] th, input logic asy, pm, sl, pk);
        logic [31:0] a;
        logic [23:0] r, n;
        logic ok, hd, lo;
        logic [1:0] es;
        int g, i, tm;
        a = ad;
        r = ct;
        ok = 1'b1;
        hd = (ad[3:0] != 4'h0);
        g = 0;
        tm = (th == 8'h00) ? 1 : int'(th);
        @(posedge clk_sys);
        #1;
        bus_async = asy;
        permit = pm;
        slow = sl;
        job = '{addr: ad, count: ct, threshold: th};
        start = 1'b1;
        @(posedge clk_sys);
        #1 start = 1'b0;
        for (i = 0; i < 400 && r != 24'h0; i++) begin
            #3;
            chk(remaining === r && busy === 1'b1, "remaining count or busy");
            if (cyc_valid === 1'b1 && cyc_ack === 1'b1) begin
                if (a[0] || r < 24'h2) es = SIZ_BYTE;
                else if (a[1] || r < 24'h4) es = SIZ_WORD;
                else if (a[3:0] != 4'h0 || r <= BURST_MIN_COUNT || !ok) es = SIZ_LONG;
                else es = SIZ_LINE;
                n = (es == SIZ_BYTE) ? BYTES_BYTE : (es == SIZ_WORD) ? BYTES_WORD :
                    (es == SIZ_LONG) ? BYTES_LONG : BYTES_LINE;
                lo = hd || r == n || es == SIZ_LINE || (!ok && es == SIZ_LONG && g + 1 >= tm);
                chk(cyc.addr === a && cyc.size === es, "cycle address or size");
                chk(cyc.burst_line === (es == SIZ_LINE), "burst marker");
                chk(cyc.last_own === lo, "ownership end");
                if (lo) g = 0;
                else if (!ok && es == SIZ_LONG) g++;
                a = a + 32'(n);
                r = r - n;
                ok = pm;
                if (a[3:0] == 4'h0) hd = 1'b0;
            end
            @(posedge clk_sys);
            #1 start = pk && (i == 2);
        end
        if (r != 24'h0) begin
            chk(1'b0, "block never finished");
            return;
        end
        #3;
        for (i = 0; i < 8 && done !== 1'b1; i++) begin
            chk(cyc_valid === 1'b0, "cycle after block end");
            @(posedge clk_sys);
            #4;
        end
        chk(done === 1'b1 && remaining === COUNT_ZERO, "done pulse");
        if (done !== 1'b1) return;
        @(posedge clk_sys);
        #4;
        chk(busy === 1'b0 && cyc_valid === 1'b0 && done === 1'b0, "idle after done");
    endtask

    // ==========================================================
    // Scenarios
    task automatic s_walk;
        run_block(32'h00000003, 24'h000030, 8'h04, 1'b1, 1'b1, 1'b0, 1'b0);
    endtask
    task automatic s_sync_refused;
        run_block(32'h00000102, 24'h000045, 8'h03, 1'b0, 1'b0, 1'b1, 1'b1);
    endtask
    task automatic s_async_refused;
        run_block(32'h00000011, 24'h000047, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
    endtask
    task automatic s_tail;
        run_block(32'h00000040, 24'h000027, 8'h02, 1'b0, 1'b1, 1'b1, 1'b0);
    endtask
    task automatic s_short;
        run_block(32'h00000005, 24'h000003, 8'h01, 1'b1, 1'b1, 1'b0, 1'b0);
    endtask
    task automatic s_empty;
        run_block(32'h00000020, 24'h000000, 8'h01, 1'b0, 1'b1, 1'b0, 1'b0);
    endtask

    // Main sequence
    initial begin
        reset = 1'b1;
        start = 1'b0;
        job = '0;
        bus_async = 1'b0;
        slow = 1'b0;
        permit = 1'b1;
        failures = 0;
        compares = 0;
        repeat (10) @(posedge clk_sys);
        #1 reset = 1'b0;
        s_walk();
        s_sync_refused();
        s_async_refused();
        s_tail();
        s_short();
        s_empty();
        close_out();
    end
endmodule // dma_transfer_alignment_sizer_tb_top

`default_nettype wire
